// >>> shared/csp_cfg.svh
// Constants for the CPU status, pointer and addressing block.
// Assumes one core clock and an SFR port driven by the core sequencer.
// What this block does
// RULE_01 - Parity bit tracks odd accumulator ones
// RULE_02 - Status word bit order carry to parity
// RULE_03 - Bank bits pick one of four banks
// RULE_04 - Carry doubles as Boolean accumulator
// RULE_05 - Two user flags are plain storage
// RULE_06 - Pointer is sixteen bits, two bytes
// RULE_07 - Two pointers share one SFR address
// RULE_08 - Select bit zero primary, one secondary
// RULE_09 - Auxiliary register: flag bit 3, select bit 0
// RULE_10 - Direct address reaches only RAM or SFR
// RULE_11 - Indirect from R0, R1, stack, pointer
// RULE_12 - Indirect reaches internal and external RAM
// RULE_13 - Three opcode bits pick working register
// RULE_14 - Immediate constant follows the opcode
// RULE_15 - Indexed reads code: base plus accumulator
// RULE_16 - Indexed jump target base plus accumulator
// RULE_17 - Stack resets 07H, increments before store
// RULE_18 - Overflow on signed add/subtract range error
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
`define CSP_SFR_SP      8'h81
`define CSP_SFR_DPL     8'h82
`define CSP_SFR_DPH     8'h83
`define CSP_SFR_AUX     8'hA2
`define CSP_SFR_PSW     8'hD0
`define CSP_SFR_BASE    8'h80
`define CSP_PSW_CY      7
`define CSP_PSW_AC      6
`define CSP_PSW_F0      5
`define CSP_PSW_RS1     4
`define CSP_PSW_RS0     3
`define CSP_PSW_OV      2
`define CSP_PSW_F1      1
`define CSP_PSW_P       0
`define CSP_AUX_GF2     3
`define CSP_AUX_DPS     0
`define CSP_AUX_MASK    8'h09
`define CSP_PSW_RST     8'h00
`define CSP_AUX_RST     8'h00
`define CSP_SP_RST      8'h07
`define CSP_DP_RST      16'h0000
`endif

// >>> shared/csp_pkg.sv
// Types for the CPU status, pointer and addressing block.
// Assumes csp_cfg.svh is on the include path.
`include "csp_cfg.svh"
package csp_pkg;
    typedef enum logic [3:0] {
        CSP_AM_REG     = 4'h0,
        CSP_AM_DIR     = 4'h1,
        CSP_AM_IND_RI  = 4'h2,
        CSP_AM_IND_SP  = 4'h3,
        CSP_AM_IND_DP  = 4'h4,
        CSP_AM_IMM     = 4'h5,
        CSP_AM_IDX_DP  = 4'h6,
        CSP_AM_IDX_PC  = 4'h7,
        CSP_AM_JMP_IDX = 4'h8
    } csp_mode_t;
    typedef enum logic [1:0] {
        CSP_SP_IRAM = 2'h0,
        CSP_SP_SFR  = 2'h1,
        CSP_SP_XRAM = 2'h2,
        CSP_SP_CODE = 2'h3
    } csp_space_t;
    typedef enum logic [2:0] {
        CSP_BO_CLR  = 3'h0,
        CSP_BO_SET  = 3'h1,
        CSP_BO_CPL  = 3'h2,
        CSP_BO_AND  = 3'h3,
        CSP_BO_OR   = 3'h4,
        CSP_BO_ANDN = 3'h5,
        CSP_BO_ORN  = 3'h6,
        CSP_BO_MOV  = 3'h7
    } csp_bitop_t;
endpackage

// >>> logic/csp_parity.sv
// Odd-parity reduction of one byte.
// Assumes the parent registers the result.
`timescale 1ns/1ps
module csp_parity
    import csp_pkg::*;
(
    // Data in
    input  wire logic [7:0] dataIn,
    // Parity out
    output logic            oddOut
);
    logic [7:0] chain;
    assign chain[0] = dataIn[0];
    genvar i;
    generate
        for (i = 1; i < 8; i++) begin : g_chain
            assign chain[i] = chain[i-1] ^ dataIn[i];
        end
    endgenerate
    assign oddOut = chain[7];
endmodule

// >>> logic/csp_addr_gen.sv
// Combinational operand address former for all addressing modes.
// Assumes the parent supplies current pointer, stack and bank values.
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_addr_gen
    import csp_pkg::*;
(
    // Request
    input  csp_mode_t        mode,
    input  wire logic        extSel,
    input  wire logic [2:0]  regSel,
    input  wire logic [7:0]  directAddr,
    input  wire logic [7:0]  riValue,
    // Core state
    input  wire logic [1:0]  bankSel,
    input  wire logic [7:0]  stackPtr,
    input  wire logic [15:0] dataPtr,
    input  wire logic [15:0] progCnt,
    input  wire logic [7:0]  accValue,
    // Result
    output logic [15:0]      addrOut,
    output csp_space_t       spaceOut,
    output logic             readOnly
);
    // Indirect bytes go to external RAM only when asked
    function automatic csp_space_t indSpace(input logic ext);
        indSpace = ext ? CSP_SP_XRAM : CSP_SP_IRAM;
    endfunction

    always_comb begin
        addrOut  = 16'h0000;
        spaceOut = CSP_SP_IRAM;
        readOnly = 1'b0;
        case (mode)
            // RULE_13 bank register address
            CSP_AM_REG: addrOut = {11'h000, bankSel, regSel};
            // RULE_10 direct RAM or SFR
            CSP_AM_DIR: begin
                addrOut  = {8'h00, directAddr};
                spaceOut = (directAddr >= `CSP_SFR_BASE) ? CSP_SP_SFR : CSP_SP_IRAM;
            end
            // RULE_11 eight-bit indirect
            CSP_AM_IND_RI: begin
                addrOut  = {8'h00, riValue};
                spaceOut = indSpace(extSel);
            end
            CSP_AM_IND_SP: begin
                addrOut  = {8'h00, stackPtr};
                spaceOut = CSP_SP_IRAM;
            end
            // RULE_12 sixteen-bit external
            CSP_AM_IND_DP: begin
                addrOut  = dataPtr;
                spaceOut = CSP_SP_XRAM;
            end
            // RULE_14 byte after opcode
            CSP_AM_IMM: begin
                addrOut  = progCnt + 16'h0001;
                spaceOut = CSP_SP_CODE;
                readOnly = 1'b1;
            end
            // RULE_15 table read
            CSP_AM_IDX_DP, CSP_AM_JMP_IDX: begin
                addrOut  = dataPtr + {8'h00, accValue};
                spaceOut = CSP_SP_CODE;
                readOnly = 1'b1;
            end
            CSP_AM_IDX_PC: begin
                addrOut  = progCnt + {8'h00, accValue};
                spaceOut = CSP_SP_CODE;
                readOnly = 1'b1;
            end
            default: begin
                addrOut  = 16'h0000;
                spaceOut = CSP_SP_IRAM;
                readOnly = 1'b0;
            end
        endcase
    end
endmodule

// >>> logic/csp_core.sv
// Status word, dual data pointer, stack pointer and address former.
// Assumes the core sequencer drives the SFR port and operation strobes
// synchronously to mclk; the accumulator itself lives outside.
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_core
    import csp_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // SFR port
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrEn,
    input  wire logic        sfrRdEn,
    input  wire logic [7:0]  sfrWrData,
    output logic [7:0]       sfrRdData,
    output logic             sfrRdHit,
    // Accumulator and arithmetic flags
    input  wire logic [7:0]  accValue,
    input  wire logic        aluEn,
    input  wire logic        aluSub,
    input  wire logic        aluUseCarry,
    input  wire logic [7:0]  aluOpB,
    // Boolean operations on carry
    input  wire logic        bitEn,
    input  csp_bitop_t       bitOp,
    input  wire logic        bitIn,
    // Pointer and stack operations
    input  wire logic        dpLoadEn,
    input  wire logic [15:0] dpLoadValue,
    input  wire logic        dpIncEn,
    input  wire logic        spPushEn,
    input  wire logic        spPopEn,
    // Address request
    input  wire logic        agenReq,
    input  csp_mode_t        agenMode,
    input  wire logic        agenExt,
    input  wire logic [2:0]  agenRegSel,
    input  wire logic [7:0]  agenDirect,
    input  wire logic [7:0]  agenRiValue,
    input  wire logic [15:0] agenPc,
    // Address answer
    output logic             agenValid,
    output logic [15:0]      agenAddr,
    output csp_space_t       agenSpace,
    output logic             agenReadOnly,
    // State views
    output logic [7:0]       pswOut,
    output logic [7:0]       auxOut,
    output logic [7:0]       spOut,
    output logic [15:0]      dpOut,
    output logic [15:0]      aluResult
);
    logic [7:0]  psw_reg;
    logic [7:0]  aux_reg;
    logic [7:0]  sp_reg;
    logic [15:0] dp_reg [2];
    logic        dpSel;
    logic [15:0] dpCur;
    logic        parityNow;
    logic [15:0] agenAddrNext;
    csp_space_t  agenSpaceNext;
    logic        agenRoNext;
    logic        wrPsw;
    logic        wrAux;
    logic        wrSp;
    logic        wrDpl;
    logic        wrDph;
    logic        cyIn;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic        aluCy;
    logic        aluAc;
    logic        aluOv;
    logic        bitCy;

    // RULE_08 select bit picks pointer
    assign dpSel = aux_reg[`CSP_AUX_DPS];
    // RULE_07 only selected pointer visible
    assign dpCur = dp_reg[dpSel];

    assign wrPsw = sfrWrEn && (sfrAddr == `CSP_SFR_PSW);
    assign wrAux = sfrWrEn && (sfrAddr == `CSP_SFR_AUX);
    assign wrSp  = sfrWrEn && (sfrAddr == `CSP_SFR_SP);
    assign wrDpl = sfrWrEn && (sfrAddr == `CSP_SFR_DPL);
    assign wrDph = sfrWrEn && (sfrAddr == `CSP_SFR_DPH);

    csp_parity u_parity (
        .dataIn (accValue),
        .oddOut (parityNow)
    );

    // RULE_03 bank bits pick register bank
    csp_addr_gen u_agen (
        .mode       (agenMode),
        .extSel     (agenExt),
        .regSel     (agenRegSel),
        .directAddr (agenDirect),
        .riValue    (agenRiValue),
        .bankSel    (psw_reg[`CSP_PSW_RS1:`CSP_PSW_RS0]),
        .stackPtr   (sp_reg),
        .dataPtr    (dpCur),
        .progCnt    (agenPc),
        .accValue   (accValue),
        .addrOut    (agenAddrNext),
        .spaceOut   (agenSpaceNext),
        .readOnly   (agenRoNext)
    );

    // Add and subtract with optional carry or borrow in
    assign cyIn = aluUseCarry & psw_reg[`CSP_PSW_CY];
    always_comb begin
        if (aluSub) begin
            sum9 = {1'b0, accValue} - {1'b0, aluOpB} - {8'h00, cyIn};
            sum5 = {1'b0, accValue[3:0]} - {1'b0, aluOpB[3:0]} - {4'h0, cyIn};
        end else begin
            sum9 = {1'b0, accValue} + {1'b0, aluOpB} + {8'h00, cyIn};
            sum5 = {1'b0, accValue[3:0]} + {1'b0, aluOpB[3:0]} + {4'h0, cyIn};
        end
    end
    assign aluCy = sum9[8];
    assign aluAc = sum5[4];
    // RULE_18 signed range overflow
    assign aluOv = aluSub
        ? ((accValue[7] != aluOpB[7]) && (sum9[7] != accValue[7]))
        : ((accValue[7] == aluOpB[7]) && (sum9[7] != accValue[7]));

    // RULE_04 carry as Boolean accumulator
    always_comb begin
        case (bitOp)
            CSP_BO_CLR:  bitCy = 1'b0;
            CSP_BO_SET:  bitCy = 1'b1;
            CSP_BO_CPL:  bitCy = ~psw_reg[`CSP_PSW_CY];
            CSP_BO_AND:  bitCy = psw_reg[`CSP_PSW_CY] & bitIn;
            CSP_BO_OR:   bitCy = psw_reg[`CSP_PSW_CY] | bitIn;
            CSP_BO_ANDN: bitCy = psw_reg[`CSP_PSW_CY] & ~bitIn;
            CSP_BO_ORN:  bitCy = psw_reg[`CSP_PSW_CY] | ~bitIn;
            CSP_BO_MOV:  bitCy = bitIn;
            default:     bitCy = psw_reg[`CSP_PSW_CY];
        endcase
    end

    // RULE_02 status word layout
    // An SFR write is the instruction's own destination, so it beats
    // any flag side effect in the same cycle; parity is never written.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            psw_reg <= `CSP_PSW_RST;
        end else begin
            // RULE_05 user flags change only here
            if (wrPsw) begin
                psw_reg[7:1] <= sfrWrData[7:1];
            end else begin
                if (aluEn) begin
                    psw_reg[`CSP_PSW_CY] <= aluCy;
                    psw_reg[`CSP_PSW_AC] <= aluAc;
                    psw_reg[`CSP_PSW_OV] <= aluOv;
                end
                if (bitEn) begin
                    psw_reg[`CSP_PSW_CY] <= bitCy;
                end
            end
            // RULE_01 parity follows accumulator
            psw_reg[`CSP_PSW_P] <= parityNow;
        end
    end

    // RULE_09 only flag and select bits stored
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            aux_reg <= `CSP_AUX_RST;
        end else if (wrAux) begin
            aux_reg <= sfrWrData & `CSP_AUX_MASK;
        end
    end

    // RULE_17 stack pre-increment
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sp_reg <= `CSP_SP_RST;
        end else if (wrSp) begin
            sp_reg <= sfrWrData;
        end else if (spPushEn) begin
            sp_reg <= sp_reg + 8'h01;
        end else if (spPopEn) begin
            sp_reg <= sp_reg - 8'h01;
        end
    end

    // RULE_06 byte or word access to each pointer
    genvar k;
    generate
        for (k = 0; k < 2; k++) begin : g_dp
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    dp_reg[k] <= `CSP_DP_RST;
                end else if (dpSel == 1'(k)) begin
                    if (dpLoadEn) begin
                        dp_reg[k] <= dpLoadValue;
                    end else if (dpIncEn) begin
                        dp_reg[k] <= dp_reg[k] + 16'h0001;
                    end else begin
                        if (wrDpl) begin
                            dp_reg[k][7:0] <= sfrWrData;
                        end
                        if (wrDph) begin
                            dp_reg[k][15:8] <= sfrWrData;
                        end
                    end
                end
            end
        end
    endgenerate

    // SFR reads answer one cycle later; unknown addresses read zero
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sfrRdData <= 8'h00;
            sfrRdHit  <= 1'b0;
        end else if (sfrRdEn) begin
            sfrRdHit <= 1'b1;
            case (sfrAddr)
                `CSP_SFR_PSW: sfrRdData <= {psw_reg[7:1], parityNow};
                `CSP_SFR_AUX: sfrRdData <= aux_reg;
                `CSP_SFR_SP:  sfrRdData <= sp_reg;
                `CSP_SFR_DPL: sfrRdData <= dpCur[7:0];
                `CSP_SFR_DPH: sfrRdData <= dpCur[15:8];
                default: begin
                    sfrRdData <= 8'h00;
                    sfrRdHit  <= 1'b0;
                end
            endcase
        end else begin
            sfrRdHit <= 1'b0;
        end
    end

    // RULE_16 jump target from pointer plus accumulator
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            agenValid    <= 1'b0;
            agenAddr     <= 16'h0000;
            agenSpace    <= CSP_SP_IRAM;
            agenReadOnly <= 1'b0;
        end else begin
            agenValid <= agenReq;
            if (agenReq) begin
                agenAddr     <= agenAddrNext;
                agenSpace    <= agenSpaceNext;
                agenReadOnly <= agenRoNext;
            end
        end
    end

    // State views, one cycle behind the state
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pswOut    <= `CSP_PSW_RST;
            auxOut    <= `CSP_AUX_RST;
            spOut     <= `CSP_SP_RST;
            dpOut     <= `CSP_DP_RST;
            aluResult <= 16'h0000;
        end else begin
            pswOut    <= psw_reg;
            auxOut    <= aux_reg;
            spOut     <= sp_reg;
            dpOut     <= dpCur;
            aluResult <= {7'h00, sum9};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    chk_parity_tracks: assert property ( // RULE_01
        ##2 pswOut[`CSP_PSW_P] == ^$past(accValue, 2)
    ) else $error("parity does not track accumulator");

    chk_psw_write_order: assert property ( // RULE_02
        wrPsw |=> psw_reg[7:1] == $past(sfrWrData[7:1])
    ) else $error("status write landed in wrong bits");

    chk_bank_reg_addr: assert property ( // RULE_13
        agenReq && agenMode == CSP_AM_REG |=>
            agenAddr == {11'h000, $past(psw_reg[4:3]), $past(agenRegSel)}
    ) else $error("register address ignores bank");

    chk_carry_bitop: assert property ( // RULE_04
        bitEn && !wrPsw && bitOp == CSP_BO_CPL |=>
            psw_reg[`CSP_PSW_CY] != $past(psw_reg[`CSP_PSW_CY])
    ) else $error("complement of carry failed");

    chk_user_flags_hold: assert property ( // RULE_05
        !wrPsw |=> $stable({psw_reg[`CSP_PSW_F0], psw_reg[`CSP_PSW_F1]})
    ) else $error("user flag changed without write");

    chk_dp_select_only: assert property ( // RULE_07
        wrDpl && !dpLoadEn && !dpIncEn && dpSel == 1'b0 |=>
            dp_reg[0][7:0] == $past(sfrWrData) && $stable(dp_reg[1])
    ) else $error("pointer write reached wrong pointer");

    chk_aux_unused_zero: assert property ( // RULE_09
        (aux_reg & ~`CSP_AUX_MASK) == 8'h00
    ) else $error("unimplemented auxiliary bit set");

    chk_direct_space: assert property ( // RULE_10
        agenReq && agenMode == CSP_AM_DIR |=>
            agenSpace inside {CSP_SP_IRAM, CSP_SP_SFR}
    ) else $error("direct address left RAM and SFR");

    chk_dp_ind_ext: assert property ( // RULE_12
        agenReq && agenMode == CSP_AM_IND_DP |=>
            agenSpace == CSP_SP_XRAM && agenAddr == $past(dpCur)
    ) else $error("pointer indirect not external");

    chk_indexed_ro: assert property ( // RULE_15
        agenReq && agenMode inside {CSP_AM_IDX_DP, CSP_AM_IDX_PC} |=>
            agenReadOnly && agenSpace == CSP_SP_CODE
    ) else $error("indexed access not code read");

    chk_jump_target: assert property ( // RULE_16
        agenReq && agenMode == CSP_AM_JMP_IDX |=>
            agenAddr == $past(dpCur) + {8'h00, $past(accValue)}
    ) else $error("jump target wrong");

    chk_sp_push_inc: assert property ( // RULE_17
        spPushEn && !wrSp |=> sp_reg == $past(sp_reg) + 8'h01
    ) else $error("stack not pre-incremented");

    chk_ov_signed: assert property ( // RULE_18
        aluEn && !wrPsw && !aluSub && accValue == 8'h7F
            && aluOpB == 8'h01 && !cyIn |=> psw_reg[`CSP_PSW_OV]
    ) else $error("signed overflow missed");

    cov_dp_switch: cover property (wrAux ##1 wrAux ##1 agenReq);
    cov_push_ind: cover property (spPushEn ##1 agenReq && agenMode == CSP_AM_IND_SP);
    cov_alu_ovf: cover property (aluEn && aluOv);
    cov_ext_ri: cover property (agenReq && agenMode == CSP_AM_IND_RI && agenExt);
endmodule

// >>> tb/tb_cpu_status_pointer_addressing.sv
// Self-checking bench for the status word, dual pointer and address former.
// Assumes csp_pkg is compiled first and csp_cfg.svh is on the include path.
`timescale 1ns/1ps
`include "csp_cfg.svh"
module tb_cpu_status_pointer_addressing
    import csp_pkg::*;
;
    logic        mclk, rstn, sfrWrEn, sfrRdEn, sfrRdHit, aluEn, aluSub, aluUseCarry;
    logic        bitEn, bitIn, dpLoadEn, dpIncEn, spPushEn, spPopEn;
    logic        agenReq, agenExt, agenValid, agenReadOnly;
    logic [7:0]  sfrAddr, sfrWrData, sfrRdData, accValue, aluOpB, agenDirect;
    logic [7:0]  agenRiValue, pswOut, auxOut, spOut;
    logic [2:0]  agenRegSel;
    logic [15:0] dpLoadValue, agenPc, agenAddr, dpOut, aluResult;
    csp_bitop_t  bitOp;
    csp_mode_t   agenMode;
    csp_space_t  agenSpace;
    int          fails, n_checks, cycleCount;

    localparam csp_bitop_t OPS [8] = '{CSP_BO_CLR, CSP_BO_SET, CSP_BO_AND, CSP_BO_OR,
                                       CSP_BO_ANDN, CSP_BO_ORN, CSP_BO_CPL, CSP_BO_MOV};

    csp_core i_dut (.mclk, .rstn, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
        .sfrRdHit, .accValue, .aluEn, .aluSub, .aluUseCarry, .aluOpB, .bitEn, .bitOp,
        .bitIn, .dpLoadEn, .dpLoadValue, .dpIncEn, .spPushEn, .spPopEn, .agenReq,
        .agenMode, .agenExt, .agenRegSel, .agenDirect, .agenRiValue, .agenPc,
        .agenValid, .agenAddr, .agenSpace, .agenReadOnly, .pswOut, .auxOut, .spOut,
        .dpOut, .aluResult);

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    // Far above the roughly 110 cycles the tests need
    always @(posedge mclk) begin
        cycleCount++;
        if (cycleCount == 3000) begin
            fails++;
            end_sim;
        end
    end

    task tick;
        @(posedge mclk);
        #1;
    endtask

    // State views trail the state by one cycle
    task settle;
        tick;
        tick;
    endtask

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        tick;
        sfrWrEn = 1'b0;
        tick;
    endtask

    task sfr_rd(input logic [7:0] a, input logic [7:0] expD, input logic expHit);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        tick;
        sfrRdEn = 1'b0;
        check("sfrRdData", 16'(sfrRdData), 16'(expD));
        check("sfrRdHit", 16'(sfrRdHit), 16'(expHit));
        tick;
    endtask

    task agen(input csp_mode_t m, input logic e, input logic [15:0] expA,
              input csp_space_t expS);
        agenMode = m;
        agenExt = e;
        agenReq = 1'b1;
        tick;
        agenReq = 1'b0;
        check("agenValid", 16'(agenValid), 16'h0001);
        check("agenAddr", agenAddr, expA);
        check("agenSpace", 16'(agenSpace), 16'(expS));
        check("agenReadOnly", 16'(agenReadOnly), 16'(expS == CSP_SP_CODE));
        tick;
    endtask

    task alu(input logic [7:0] a, input logic [7:0] b, input logic sub, input logic uc,
             input logic [2:0] expCao, input logic [15:0] expR);
        accValue = a;
        aluOpB = b;
        aluSub = sub;
        aluUseCarry = uc;
        aluEn = 1'b1;
        tick;
        aluEn = 1'b0;
        tick;
        check("cyAcOv", 16'({pswOut[7:6], pswOut[2]}), 16'(expCao));
        check("aluResult", aluResult, expR);
    endtask

    task test_reset;
        settle;
        check("pswOut", 16'(pswOut), 16'h0000);
        check("auxOut", 16'(auxOut), 16'h0000);
        check("spOut", 16'(spOut), 16'h0007);
        check("dpOut", dpOut, 16'h0000);
        $display("test reset done");
    endtask

    task test_psw;
        accValue = 8'h01;
        tick;
        sfr_wr(`CSP_SFR_PSW, 8'h33);
        sfr_rd(`CSP_SFR_PSW, 8'h33, 1'b1);
        accValue = 8'h03;
        tick;
        sfr_rd(`CSP_SFR_PSW, 8'h32, 1'b1);
        accValue = 8'hFE;
        settle;
        check("pswOut", 16'(pswOut), 16'h0033);
        sfr_rd(8'h84, 8'h00, 1'b0);
        $display("test status word done");
    endtask

    task test_banks;
        agenRegSel = 3'h7;
        for (int b = 0; b < 4; b++) begin
            sfr_wr(`CSP_SFR_PSW, {3'h0, 2'(b), 3'h0});
            agen(CSP_AM_REG, 1'b0, {11'h000, 2'(b), 3'h7}, CSP_SP_IRAM);
        end
        $display("test banks done");
    endtask

    task test_carry;
        logic [7:0] ins;
        logic [7:0] exp;
        ins = 8'h98;
        exp = 8'hAA;
        for (int i = 0; i < 8; i++) begin
            bitOp = OPS[i];
            bitIn = ins[i];
            bitEn = 1'b1;
            tick;
            bitEn = 1'b0;
            tick;
            check("carry", 16'(pswOut[7]), 16'(exp[i]));
        end
        $display("test carry done");
    endtask

    task test_alu;
        alu(8'h7F, 8'h01, 1'b0, 1'b0, 3'b011, 16'h0080);
        alu(8'h80, 8'h01, 1'b1, 1'b0, 3'b011, 16'h007F);
        alu(8'h00, 8'h01, 1'b1, 1'b0, 3'b110, 16'h01FF);
        alu(8'hFF, 8'h00, 1'b0, 1'b1, 3'b110, 16'h0100);
        $display("test arithmetic flags done");
    endtask

    task test_pointer;
        sfr_wr(`CSP_SFR_AUX, 8'h00);
        sfr_wr(`CSP_SFR_DPL, 8'hFF);
        sfr_wr(`CSP_SFR_DPH, 8'h01);
        settle;
        check("dpOut", dpOut, 16'h01FF);
        sfr_wr(`CSP_SFR_AUX, 8'hFF);
        sfr_rd(`CSP_SFR_AUX, 8'h09, 1'b1);
        settle;
        check("dpOut", dpOut, 16'h0000);
        dpLoadValue = 16'h02FF;
        dpLoadEn = 1'b1;
        tick;
        dpLoadEn = 1'b0;
        sfr_rd(`CSP_SFR_DPH, 8'h02, 1'b1);
        sfr_rd(`CSP_SFR_DPL, 8'hFF, 1'b1);
        sfr_wr(`CSP_SFR_AUX, 8'h08);
        settle;
        check("dpOut", dpOut, 16'h01FF);
        check("auxOut", 16'(auxOut), 16'h0008);
        dpIncEn = 1'b1;
        tick;
        dpIncEn = 1'b0;
        settle;
        check("dpOut", dpOut, 16'h0200);
        $display("test pointers done");
    endtask

    task test_modes;
        spPushEn = 1'b1;
        tick;
        spPushEn = 1'b0;
        settle;
        check("spOut", 16'(spOut), 16'h0008);
        agen(CSP_AM_IND_SP, 1'b0, 16'h0008, CSP_SP_IRAM);
        agenRiValue = 8'h40;
        agen(CSP_AM_IND_RI, 1'b0, 16'h0040, CSP_SP_IRAM);
        agen(CSP_AM_IND_RI, 1'b1, 16'h0040, CSP_SP_XRAM);
        agen(CSP_AM_IND_DP, 1'b0, 16'h0200, CSP_SP_XRAM);
        agenDirect = 8'h7F;
        agen(CSP_AM_DIR, 1'b0, 16'h007F, CSP_SP_IRAM);
        agenDirect = 8'h80;
        agen(CSP_AM_DIR, 1'b0, 16'h0080, CSP_SP_SFR);
        agenPc = 16'h1234;
        accValue = 8'h03;
        agen(CSP_AM_IMM, 1'b0, 16'h1235, CSP_SP_CODE);
        agen(CSP_AM_IDX_DP, 1'b0, 16'h0203, CSP_SP_CODE);
        agen(CSP_AM_IDX_PC, 1'b0, 16'h1237, CSP_SP_CODE);
        agen(CSP_AM_JMP_IDX, 1'b0, 16'h0203, CSP_SP_CODE);
        spPopEn = 1'b1;
        tick;
        spPopEn = 1'b0;
        settle;
        check("spOut", 16'(spOut), 16'h0007);
        $display("test addressing done");
    endtask

    initial begin
        {rstn, sfrWrEn, sfrRdEn, aluEn, aluSub, aluUseCarry, bitEn, bitIn} = 8'h00;
        {dpLoadEn, dpIncEn, spPushEn, spPopEn, agenReq, agenExt} = 6'h00;
        {sfrAddr, sfrWrData, accValue, aluOpB, agenDirect, agenRiValue} = 48'h0;
        {agenRegSel, dpLoadValue, agenPc} = 35'h0;
        bitOp = CSP_BO_CLR;
        agenMode = CSP_AM_REG;
        repeat (2) tick;
        rstn = 1'b1;
        test_reset;
        test_psw;
        test_banks;
        test_carry;
        test_alu;
        test_pointer;
        test_modes;
        end_sim;
    end
endmodule
